// File: src/rivm_vector_map.sv
// Reset and interrupt vector address generator.
// Assumes requests arrive on clk_sys from enabled, already-unmasked sources and
// that the fetch logic acknowledges a vector with vec_ack.
`timescale 1ns/1ps
`default_nettype none

module rivm_vector_map #(
  parameter bit          LARGE_PART = 1'b1,
  parameter logic [15:0] BOOT_START = 16'h1C00
) (
  input  wire logic                     clk_sys,
  input  wire logic                     srst,
  input  wire rivm_pkg::rivm_place_t    place,
  input  wire logic [rivm_pkg::IRQ_COUNT-1:0] irq_req,
  input  wire logic                     vec_ack,
  output logic                          vec_valid,
  output rivm_pkg::rivm_vector_t        vec_out,
  output logic [15:0]                   reset_addr,
  output logic [15:0]                   table_base
);
  import rivm_pkg::*;

  // Refused at elaboration: the small part only has the 2 Kbyte boot section.
  if (!LARGE_PART && BOOT_START != BOOT_RESET_SMALL)
  begin : g_bad_boot
    $error("rivm_vector_map: small part boot start must be 0xC00 for a 2 Kbyte section");
  end

  // Word spacing between vectors; chosen per part variant.
  localparam logic [15:0] PITCH = LARGE_PART ? PITCH_LARGE : PITCH_SMALL;

  // Address of vector number n (1 = reset) relative to the table base.
  function automatic logic [15:0] slot_offset(input logic [4:0] n);
    logic [15:0] idx;
    idx = {11'h000, n} - 16'h0001;
    return 16'(idx * PITCH);
  endfunction

  rivm_state_t  state_q, state_d;
  rivm_vector_t vec_q,   vec_d;
  logic         valid_q, valid_d;
  logic         any_req;
  logic [4:0]   win_idx;
  logic         fuse_programmed;
  logic         relocate;

  // Lowest index means lowest vector number, so it is served first.
  rivm_prio_enc #(
    .WIDTH (IRQ_COUNT)
  ) u_prio (
    .req   (irq_req),
    .any   (any_req),
    .index (win_idx)
  );

  // Placement decode; fuse and select bit steer separate outputs only.
  assign fuse_programmed = (place.boot_reset_fuse != FUSE_UNPROGRAMMED);
  assign relocate        = place.vector_select_bit;
  assign reset_addr      = fuse_programmed ? BOOT_START : APP_RESET_ADDR;
  assign table_base      = relocate ? BOOT_START : APP_RESET_ADDR;

  // Next-state logic: a reset vector is issued first after srst, then interrupts.
  // Holding the vector until ack keeps the fetch side from seeing a changing address.
  always_comb
  begin
    state_d = state_q;
    vec_d   = vec_q;
    valid_d = valid_q;
    case (state_q)
      ST_RESET:
      begin
        vec_d.is_reset = 1'b1;
        vec_d.number   = 5'd1;
        vec_d.address  = reset_addr;
        valid_d        = 1'b1;
        state_d        = ST_WAIT;
      end
      ST_IDLE:
      begin
        if (any_req)
        begin
          vec_d.is_reset = 1'b0;
          vec_d.number   = 5'(win_idx + 5'd2);
          vec_d.address  = 16'(table_base + slot_offset(5'(win_idx + 5'd2)));
          valid_d        = 1'b1;
          state_d        = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (vec_ack)
        begin
          valid_d = 1'b0;
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        valid_d = 1'b0;
        state_d = ST_IDLE;
      end
    endcase
  end

  // State registers.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_q         <= ST_RESET;
      valid_q         <= 1'b0;
      vec_q.is_reset  <= 1'b0;
      vec_q.number    <= RST_INDEX;
      vec_q.address   <= RST_VECTOR;
    end
    else
    begin
      state_q <= state_d;
      valid_q <= valid_d;
      vec_q   <= vec_d;
    end
  end

  assign vec_valid = valid_q;
  assign vec_out   = vec_q;

  // Reset vector issued one cycle after reset release, at the fuse-selected address.
  reset_vec_addr_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_RESET) |=> (vec_valid && vec_out.is_reset && vec_out.address == $past(reset_addr)))
    else $error("reset vector address wrong");

  // Unprogrammed fuse gives address zero.
  app_reset_a: assert property (@(posedge clk_sys)
    place.boot_reset_fuse |-> reset_addr == 16'h0000)
    else $error("application reset address not zero");

  // Programmed fuse gives boot start.
  boot_reset_a: assert property (@(posedge clk_sys)
    !place.boot_reset_fuse |-> reset_addr == BOOT_START)
    else $error("boot reset address wrong");

  // External request 0 alone maps to the second slot.
  ext0_addr_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req[0]) |=> vec_out.address == $past(table_base) + PITCH)
    else $error("external request 0 vector wrong");

  // Last vector lands at slot 26.
  last_vec_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h100_0000) |=>
      (vec_out.number == 5'd26 && vec_out.address == $past(table_base) + 16'(25 * PITCH)))
    else $error("last vector address wrong");

  // Lowest pending request wins.
  prio_low_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req[5] && irq_req[20]) |=> vec_out.number == 5'd7)
    else $error("priority order violated");

  // Reset vector always carries number one.
  reset_num_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_RESET) |=> vec_out.number == 5'd1)
    else $error("reset vector number wrong");

  // Reset withdraws any offer on the next edge.
  rst_clear_a: assert property (@(posedge clk_sys)
    srst |=> !vec_valid)
    else $error("offer survived reset");

  // An acknowledged offer is withdrawn one cycle later.
  valid_drop_a: assert property (@(posedge clk_sys) disable iff (srst)
    (vec_valid && vec_ack) |=> !vec_valid)
    else $error("offer not withdrawn after acknowledge");

  // In idle, nothing is offered while no request is pending.
  idle_quiet_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h000_0000) |=> !vec_valid)
    else $error("offer without a request");

  // External request 1 maps to vector 3.
  ext1_addr_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h000_0002) |=>
      (vec_out.number == 5'd3 && vec_out.address == $past(table_base) + 16'(2 * PITCH)))
    else $error("external request 1 vector wrong");

  // Pin change request 0 maps to vector 4.
  pin_chg0_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h000_0004) |=>
      (vec_out.number == 5'd4 && vec_out.address == $past(table_base) + 16'(3 * PITCH)))
    else $error("pin change request 0 vector wrong");

  // Pin change request 1 maps to vector 5.
  pin_chg1_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h000_0008) |=>
      (vec_out.number == 5'd5 && vec_out.address == $past(table_base) + 16'(4 * PITCH)))
    else $error("pin change request 1 vector wrong");

  // Pin change request 2 maps to vector 6.
  pin_chg2_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h000_0010) |=>
      (vec_out.number == 5'd6 && vec_out.address == $past(table_base) + 16'(5 * PITCH)))
    else $error("pin change request 2 vector wrong");

  // Watchdog timeout interrupt maps to vector 7, not to the reset vector.
  wdog_vec_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h000_0020) |=>
      (vec_out.number == 5'd7 && !vec_out.is_reset && vec_out.address == $past(table_base) + 16'(6 * PITCH)))
    else $error("watchdog timeout vector wrong");

  // Timer 2 compare A maps to vector 8.
  tmr2_cmpa_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h000_0040) |=>
      (vec_out.number == 5'd8 && vec_out.address == $past(table_base) + 16'(7 * PITCH)))
    else $error("timer 2 compare A vector wrong");

  // Timer 2 overflow maps to vector 10.
  tmr2_ovf_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h000_0100) |=>
      (vec_out.number == 5'd10 && vec_out.address == $past(table_base) + 16'(9 * PITCH)))
    else $error("timer 2 overflow vector wrong");

  // Timer 1 capture maps to vector 11.
  tmr1_cap_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h000_0200) |=>
      (vec_out.number == 5'd11 && vec_out.address == $past(table_base) + 16'(10 * PITCH)))
    else $error("timer 1 capture vector wrong");

  // Timer 1 overflow maps to vector 14.
  tmr1_ovf_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h000_1000) |=>
      (vec_out.number == 5'd14 && vec_out.address == $past(table_base) + 16'(13 * PITCH)))
    else $error("timer 1 overflow vector wrong");

  // Timer 0 compare A maps to vector 15.
  tmr0_cmpa_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h000_2000) |=>
      (vec_out.number == 5'd15 && vec_out.address == $past(table_base) + 16'(14 * PITCH)))
    else $error("timer 0 compare A vector wrong");

  // Timer 0 overflow maps to vector 17.
  tmr0_ovf_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h000_8000) |=>
      (vec_out.number == 5'd17 && vec_out.address == $past(table_base) + 16'(16 * PITCH)))
    else $error("timer 0 overflow vector wrong");

  // Transfer complete maps to vector 18.
  xfer_done_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h001_0000) |=>
      (vec_out.number == 5'd18 && vec_out.address == $past(table_base) + 16'(17 * PITCH)))
    else $error("transfer complete vector wrong");

  // Serial receive complete maps to vector 19.
  rx_done_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h002_0000) |=>
      (vec_out.number == 5'd19 && vec_out.address == $past(table_base) + 16'(18 * PITCH)))
    else $error("receive complete vector wrong");

  // Transmit buffer empty maps to vector 20.
  tx_empty_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h004_0000) |=>
      (vec_out.number == 5'd20 && vec_out.address == $past(table_base) + 16'(19 * PITCH)))
    else $error("transmit buffer empty vector wrong");

  // Serial transmit complete maps to vector 21.
  tx_done_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h008_0000) |=>
      (vec_out.number == 5'd21 && vec_out.address == $past(table_base) + 16'(20 * PITCH)))
    else $error("transmit complete vector wrong");

  // Conversion complete maps to vector 22.
  conv_done_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h010_0000) |=>
      (vec_out.number == 5'd22 && vec_out.address == $past(table_base) + 16'(21 * PITCH)))
    else $error("conversion complete vector wrong");

  // Two-wire port maps to vector 25.
  two_wire_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == ST_IDLE && irq_req == 25'h080_0000) |=>
      (vec_out.number == 5'd25 && vec_out.address == $past(table_base) + 16'(24 * PITCH)))
    else $error("two-wire port vector wrong");

  // Relocation follows the select bit regardless of the fuse.
  reloc_base_a: assert property (@(posedge clk_sys)
    place.vector_select_bit |-> table_base == BOOT_START)
    else $error("vector table not relocated");

  // Vector holds stable until acknowledged.
  vec_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    (vec_valid && !vec_ack) |=> (vec_valid && $stable(vec_out)))
    else $error("vector changed before acknowledge");

endmodule
`default_nettype wire

// File: src/rivm_pkg.sv
// Package for the reset and interrupt vector map.
// Assumes one system clock and a synchronous active-high reset.
package rivm_pkg;

  localparam int unsigned NUM_SRC        = 26;
  localparam int unsigned IRQ_COUNT      = 25;
  localparam int unsigned ADDR_W         = 16;

  // Vector pitch in words: two on the larger part, one on the smaller.
  localparam logic [15:0] PITCH_LARGE    = 16'h0002;
  localparam logic [15:0] PITCH_SMALL    = 16'h0001;
  localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
  localparam logic [15:0] BOOT_RESET_SMALL = 16'h0C00;

  // Fuse encoding: 1 is unprogrammed, 0 is programmed.
  localparam logic FUSE_UNPROGRAMMED     = 1'b1;

  // Reset values of the registered outputs.
  localparam logic [15:0] RST_VECTOR     = 16'h0000;
  localparam logic [4:0]  RST_INDEX      = 5'h00;

  typedef enum logic [1:0]
  {
    ST_RESET = 2'b00,
    ST_IDLE  = 2'b01,
    ST_WAIT  = 2'b10
  } rivm_state_t;

  // Vector request towards the fetch logic.
  typedef struct packed
  {
    logic        is_reset;
    logic [4:0]  number;
    logic [15:0] address;
  } rivm_vector_t;

  // Placement controls: fuse and relocation bit.
  typedef struct packed
  {
    logic boot_reset_fuse;
    logic vector_select_bit;
  } rivm_place_t;

endpackage

// File: src/rivm_prio_enc.sv
// Fixed-priority encoder: lowest request index wins.
// Assumes requests are already enabled and unmasked upstream.
`timescale 1ns/1ps
`default_nettype none
module rivm_prio_enc #(
  parameter int unsigned WIDTH = 25
) (
  input  wire logic [WIDTH-1:0] req,
  output logic                  any,
  output logic [4:0]            index
);
  import rivm_pkg::*;

  // Refused at elaboration: the index is five bits wide.
  if (WIDTH < 1 || WIDTH > 31)
  begin : g_bad_width
    $error("rivm_prio_enc: WIDTH out of range");
  end

  // Scan from the top so the lowest set bit is the last writer.
  always_comb
  begin
    any   = |req;
    index = 5'h00;
    for (int i = WIDTH - 1; i >= 0; i--)
    begin
      if (req[i])
        index = 5'(i);
    end
  end

endmodule
`default_nettype wire

// File: testbench/rivm_fetch_model.sv
// Fetch-side model: takes each offered vector after a set stall.
// Assumes vec_valid holds until acknowledged.
`timescale 1ns/1ps
`default_nettype none
module rivm_fetch_model (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       vec_valid,
  input  wire logic [3:0] stall,
  output logic            vec_ack
);
  logic [3:0] wait_q;
  // One ack pulse per offer; a long stall shows the offer must stand.
  always_ff @(posedge clk_sys)
  begin
    if (srst || !vec_valid || vec_ack)
    begin
      wait_q  <= 4'h0;
      vec_ack <= 1'b0;
    end
    else
    begin
      wait_q  <= wait_q + 4'h1;
      vec_ack <= (wait_q >= stall);
    end
  end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the vector map, large part, boot start 0x1C00.
// Assumes the fetch model acknowledges every vector.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rivm_pkg::*;
  localparam logic [15:0] BOOT = 16'h1C00;
  logic                 clk_sys;
  logic                 srst;
  logic                 vec_ack;
  logic                 vec_valid;
  logic [3:0]           stall;
  logic [IRQ_COUNT-1:0] irq_req;
  logic [15:0]          reset_addr;
  logic [15:0]          table_base;
  rivm_place_t          place;
  rivm_vector_t         vec_out;
  int                   mismatches;
  int                   n_compared;
  rivm_vector_map #(.LARGE_PART(1'b1), .BOOT_START(BOOT)) dut (.clk_sys(clk_sys), .srst(srst),
    .place(place), .irq_req(irq_req), .vec_ack(vec_ack), .vec_valid(vec_valid),
    .vec_out(vec_out), .reset_addr(reset_addr), .table_base(table_base));
  rivm_fetch_model fetch (.clk_sys(clk_sys), .srst(srst), .vec_valid(vec_valid),
    .stall(stall), .vec_ack(vec_ack));
  // Free-running system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Samples one offer, drops the served request, then waits out the ack.
  task automatic take(logic rst, logic [4:0] num, logic [15:0] adr, logic [IRQ_COUNT-1:0] clr);
    int n;
    n = 0;
    while (vec_valid !== 1'b1 && n < 20)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("valid", 16'h0001, {15'h0, vec_valid});
    chk("is_reset", {15'h0, rst}, {15'h0, vec_out.is_reset});
    chk("number", {11'h0, num}, {11'h0, vec_out.number});
    chk("address", adr, vec_out.address);
    @(posedge clk_sys);
    irq_req <= irq_req & ~clr;
    n = 0;
    while (vec_valid !== 1'b0 && n < 20)
    begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
  endtask
  task automatic do_reset(logic fuse, logic sel);
    @(posedge clk_sys);
    place <= '{boot_reset_fuse: fuse, vector_select_bit: sel};
    srst  <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(negedge clk_sys);
  endtask
  // All four fuse and select combinations, reset vector and first interrupt.
  task automatic test_placement();
    logic [15:0] ra;
    logic [15:0] tb;
    for (int k = 0; k < 4; k++)
    begin
      ra = k[1] ? 16'h0000 : BOOT;
      tb = k[0] ? BOOT : 16'h0000;
      do_reset(k[1], k[0]);
      chk("reset_addr", ra, reset_addr);
      chk("table_base", tb, table_base);
      take(1'b1, 5'd1, ra, '0);
      irq_req <= 25'h000_0001;
      take(1'b0, 5'd2, tb + 16'h0002, 25'h000_0001);
    end
  endtask
  // Every interrupt source in the application table.
  task automatic test_all_vectors();
    do_reset(1'b1, 1'b0);
    take(1'b1, 5'd1, 16'h0000, '0);
    for (int i = 0; i < IRQ_COUNT; i++)
    begin
      irq_req <= 25'h000_0001 << i;
      take(1'b0, 5'(i + 2), 16'((i + 1) * 2), 25'h000_0001 << i);
    end
  endtask
  // Three requests at once under a slow fetch: lowest number first.
  task automatic test_priority();
    stall   <= 4'h3;
    irq_req <= 25'h100_0000 | 25'h010_0000 | 25'h000_0020;
    take(1'b0, 5'd7, 16'h000C, 25'h000_0020);
    take(1'b0, 5'd22, 16'h002A, 25'h010_0000);
    take(1'b0, 5'd26, 16'h0032, 25'h100_0000);
    stall <= 4'h0;
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence.
  initial
  begin
    mismatches = 0;
    n_compared = 0;
    srst       = 1'b1;
    irq_req    = '0;
    stall      = 4'h0;
    place      = '{boot_reset_fuse: 1'b1, vector_select_bit: 1'b0};
    test_placement();
    test_all_vectors();
    test_priority();
    wrap_up();
  end
  // Watchdog: the tests need well under 1000 cycles.
  initial
  begin
    #100us;
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
